// >>> hdl/dmc_pkg.sv
// constants, command layout and timing for the dual converter mode, reset and clear control
// assumes a 25 MHz system clock and 24-bit command words handed over by a serial engine
package dmc_pkg;
  // system clock
  localparam int unsigned CLK_MHZ          = 25;
  // full software reset time in ns, and the cycles it takes (rounded up)
  localparam int unsigned SWRST_TIME_NS    = 5000;
  localparam int unsigned SWRST_CYCLES     = (SWRST_TIME_NS * CLK_MHZ + 999) / 1000;
  // power-on reset hold in cycles
  localparam int unsigned POR_CYCLES       = 16;
  localparam int unsigned CNT_W            = 8;
  // channels and code width
  localparam int unsigned NCH              = 2;
  localparam int unsigned CODE_W           = 16;
  // opcodes
  localparam logic [2:0]  OP_POWER         = 3'h4;
  localparam logic [2:0]  OP_SWRESET       = 3'h5;
  localparam logic [2:0]  OP_REFSET        = 3'h7;
  // field positions in the data part of a command
  localparam int unsigned PM_LO_POS        = 4;
  localparam int unsigned PM_HI_POS        = 5;
  localparam int unsigned MODE_BIT_POS     = 0;
  // power modes
  localparam logic [1:0]  PM_NORMAL        = 2'h0;
  localparam logic [1:0]  PM_1K            = 2'h1;
  localparam logic [1:0]  PM_100K          = 2'h2;
  localparam logic [1:0]  PM_TRISTATE      = 2'h3;
  // apb register offsets
  localparam logic [7:0]  OFF_STATUS       = 8'h00;
  localparam logic [7:0]  OFF_STRB_MASK    = 8'h04;
  localparam logic [7:0]  OFF_CODE_A       = 8'h08;
  localparam logic [7:0]  OFF_CODE_B       = 8'h0C;
  // status field positions
  localparam int unsigned ST_PMODE_POS     = 0;
  localparam int unsigned ST_REF_POS       = 4;
  localparam int unsigned ST_ZERO_POS      = 5;
  localparam int unsigned ST_POR_POS       = 6;
  localparam int unsigned ST_RST_POS       = 7;
  // reset values
  localparam logic [1:0]  STRB_MASK_RST    = 2'h0;
  localparam logic [CODE_W-1:0] CODE_RST   = 16'h0000;

  // one command word as it arrives from the serial engine
  typedef struct packed {
    logic                reserved;
    logic                byte_sel;
    logic [2:0]          opcode;
    logic [2:0]          chan_addr;
    logic [CODE_W-1:0]   data;
  } dmc_cmd_s;
endpackage

// >>> hdl/dmc_ctrl.sv
// mode, reset and clear control of a dual voltage-output converter, with an apb register port
// assumes a serial engine on clk hands over decoded words and framing; pins are asynchronous
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
module dmc_ctrl
  import dmc_pkg::*;
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   nrst,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // serial engine side
  input  wire logic                   scl,
  input  wire logic                   xfer_start,
  input  wire logic                   last_ack,
  input  wire logic                   hs_mode,
  input  wire logic                   cmd_valid,
  input  wire dmc_cmd_s               cmd,
  input  wire logic [NCH-1:0]         in_wr,
  input  wire logic [CODE_W-1:0]      in_data,
  output logic                        xfer_ignore,
  output logic                        xfer_abort,
  output logic                        hs_exit,
  // pins
  input  wire logic                   load_strobe_n,
  input  wire logic                   zero_output_n_i,
  output logic                        zero_output_n_o,
  output logic                        zero_output_n_oe,
  // converter side
  output logic [NCH*CODE_W-1:0]       out_code,
  output logic [NCH*2-1:0]            power_mode,
  output logic                        ref_on
);

  typedef enum logic [1:0] {ST_POR, ST_RUN, ST_FULLRST} dmc_state_e;

  dmc_state_e              state_q, state_d;
  logic [CNT_W-1:0]        cnt_q, cnt_d;
  logic [2:0]              scl_q, clr_q, ls_q;
  logic [NCH-1:0]          mask_q;
  logic [1:0]              pm_q [NCH];
  logic [CODE_W-1:0]       in_q [NCH];
  logic [CODE_W-1:0]       dac_q [NCH];
  logic                    ref_q, zero_hold_q, bad_xfer_q, busy_q;
  logic                    xfer_abort_q, hs_exit_q;

  // named decode wires
  wire logic por_busy   = (state_q == ST_POR);
  wire logic rst_busy   = (state_q == ST_FULLRST);
  wire logic scl_fall   = scl_q[2] & ~scl_q[1];
  wire logic clr_low    = ~clr_q[1];
  wire logic clr_fall   = clr_q[2] & ~clr_q[1] & ~por_busy & ~rst_busy;
  wire logic ls_fall    = ls_q[2] & ~ls_q[1] & ~por_busy & ~clr_low;
  wire logic cmd_ok     = cmd_valid & ~cmd.reserved & ~bad_xfer_q & ~rst_busy & ~por_busy & ~clr_fall;
  wire logic do_power   = cmd_ok & (cmd.opcode == OP_POWER);
  wire logic do_swrst   = cmd_ok & (cmd.opcode == OP_SWRESET);
  wire logic do_ref     = cmd_ok & (cmd.opcode == OP_REFSET);
  wire logic full_rst   = do_swrst & cmd.data[MODE_BIT_POS];
  wire logic zero_regs  = do_swrst | clr_fall;
  wire logic write_end  = scl_fall & last_ack & busy_q & ~bad_xfer_q;
  wire logic apb_wr     = psel & penable & pwrite;
  wire logic sel_status = (paddr == OFF_STATUS);
  wire logic sel_mask   = (paddr == OFF_STRB_MASK);
  wire logic sel_code_a = (paddr == OFF_CODE_A);
  wire logic sel_code_b = (paddr == OFF_CODE_B);
  wire logic sel_any    = sel_status | sel_mask | sel_code_a | sel_code_b;

  // pin synchronisers, third stage only for edge finding
  always_ff @(posedge clk) begin
    if (!nrst) begin
      scl_q <= 3'h7;
      clr_q <= 3'h7;
      ls_q  <= 3'h7;
    end else begin
      scl_q <= {scl_q[1:0], scl};
      clr_q <= {clr_q[1:0], zero_output_n_i};
      ls_q  <= {ls_q[1:0], load_strobe_n};
    end
  end

  // power-on and full reset sequencing
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      ST_POR: begin
        cnt_d = cnt_q + 8'h01;
        if (cnt_q == CNT_W'(POR_CYCLES - 1)) begin
          state_d = ST_RUN;
          cnt_d   = '0;
        end
      end
      ST_RUN: begin
        if (full_rst) begin
          state_d = ST_FULLRST;
          cnt_d   = '0;
        end
      end
      ST_FULLRST: begin
        cnt_d = cnt_q + 8'h01;
        if (cnt_q == CNT_W'(SWRST_CYCLES - 1)) begin
          state_d = ST_RUN;
          cnt_d   = '0;
        end
      end
      default: state_d = ST_POR;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= ST_POR;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // transaction tracking: a transfer starting in full reset is ignored to its end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      bad_xfer_q <= 1'h0;
      busy_q     <= 1'h0;
    end else begin
      if (xfer_start) begin
        bad_xfer_q <= rst_busy | por_busy;
        busy_q     <= 1'h1;
      end else if (write_end || (scl_fall && last_ack)) begin
        bad_xfer_q <= 1'h0;
        busy_q     <= 1'h0;
      end else if (clr_fall) begin
        // abandon write on clear: the rest of the transfer is dropped
        bad_xfer_q <= bad_xfer_q | busy_q;
        busy_q     <= 1'h0;
      end
    end
  end

  // clear side effects toward the serial engine
  always_ff @(posedge clk) begin
    if (!nrst) begin
      xfer_abort_q <= 1'h0;
      hs_exit_q    <= 1'h0;
    end else begin
      xfer_abort_q <= clr_fall & busy_q;
      hs_exit_q    <= clr_fall & hs_mode;
    end
  end

  // zero hold after power-up or clear
  always_ff @(posedge clk) begin
    if (!nrst) begin
      zero_hold_q <= 1'h1;
    end else if (clr_fall) begin
      zero_hold_q <= 1'h1;
    end else if (write_end) begin
      zero_hold_q <= 1'h0;
    end
  end

  // reference enable and load strobe mask
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ref_q  <= 1'h0;
      mask_q <= STRB_MASK_RST;
    end else if (full_rst) begin
      ref_q  <= 1'h0;
      mask_q <= STRB_MASK_RST;
    end else begin
      if (do_ref) ref_q <= cmd.data[MODE_BIT_POS];
      if (apb_wr && sel_mask) mask_q <= pwdata[NCH-1:0];
    end
  end

  // per channel power mode, input and converter registers
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    always_ff @(posedge clk) begin
      if (!nrst || full_rst) begin
        pm_q[i] <= PM_NORMAL;
      end else if (do_power && cmd.data[i]) begin
        pm_q[i] <= cmd.data[PM_HI_POS:PM_LO_POS];
      end
    end

    always_ff @(posedge clk) begin
      if (!nrst || zero_regs) begin
        in_q[i]  <= CODE_RST;
        dac_q[i] <= CODE_RST;
      end else begin
        if (in_wr[i] && !bad_xfer_q && !rst_busy) in_q[i] <= in_data;
        if (mask_q[i] && in_wr[i] && !bad_xfer_q && !rst_busy) begin
          dac_q[i] <= in_data;
        end else if (ls_fall && !mask_q[i]) begin
          dac_q[i] <= in_q[i];
        end
      end
    end

    assign out_code[i*CODE_W +: CODE_W] = zero_hold_q ? CODE_RST : dac_q[i];
    assign power_mode[i*2 +: 2]         = pm_q[i];
  end

  // clear line driven low during full reset
  assign zero_output_n_o  = 1'h0;
  assign zero_output_n_oe = ~rst_busy;

  assign ref_on      = ref_q;
  assign xfer_ignore = bad_xfer_q | rst_busy;
  assign xfer_abort  = xfer_abort_q;
  assign hs_exit     = hs_exit_q;

  // apb read mux, zero-wait answer
  wire logic [31:0] status_w = {24'h0, rst_busy, por_busy, zero_hold_q, ref_q,
                                pm_q[1], pm_q[0]};
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      if (sel_status) prdata <= status_w;
      else if (sel_mask) prdata <= {30'h0, mask_q};
      else if (sel_code_a) prdata <= {16'h0, dac_q[0]};
      else if (sel_code_b) prdata <= {16'h0, dac_q[1]};
      else prdata <= 32'h0;
    end
  end
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~sel_any;

  // checks
  a_pm_update: assert property (@(posedge clk) disable iff (!nrst)
    do_power && cmd.data[0] && !full_rst |=> pm_q[0] == $past(cmd.data[5:4]))
    else $error("power mode A not taken");
  a_pm_keep: assert property (@(posedge clk) disable iff (!nrst)
    do_power && !cmd.data[1] |=> $stable(pm_q[1]))
    else $error("unselected channel B changed");
  a_ref_off: assert property (@(posedge clk) disable iff (!nrst)
    full_rst |=> !ref_on)
    else $error("reference survived full reset");
  a_ref_cmd: assert property (@(posedge clk) disable iff (!nrst)
    do_ref && !full_rst |=> ref_on == $past(cmd.data[0]))
    else $error("reference command ignored");
  sequence s_rst_start;
    full_rst;
  endsequence
  sequence s_clr_low;
    !zero_output_n_oe [*8];
  endsequence
  a_clr_pulse: assert property (@(posedge clk) disable iff (!nrst)
    s_rst_start |=> s_clr_low ##[1:200] zero_output_n_oe)
    else $error("clear pulse wrong length");
  a_rst_ignore: assert property (@(posedge clk) disable iff (!nrst)
    xfer_start && rst_busy |=> xfer_ignore)
    else $error("transaction in reset not ignored");
  a_clr_zero: assert property (@(posedge clk) disable iff (!nrst)
    clr_fall |=> out_code == '0 && dac_q[0] == CODE_RST && in_q[1] == CODE_RST)
    else $error("clear did not zero");
  a_strobe_blk: assert property (@(posedge clk) disable iff (!nrst)
    clr_low && !in_wr[0] && !zero_regs |=> $stable(dac_q[0]))
    else $error("strobe acted while clear low");
  a_hs_exit: assert property (@(posedge clk) disable iff (!nrst)
    clr_fall && hs_mode |=> hs_exit)
    else $error("high speed not left");
  a_hold_end: assert property (@(posedge clk) disable iff (!nrst)
    write_end && !clr_fall |=> !zero_hold_q)
    else $error("zero hold not released");
  a_por_ignore: assert property (@(posedge clk) disable iff (!nrst)
    por_busy |=> zero_hold_q && $stable(dac_q[0]))
    else $error("activity during power-on");

  // checks on abort, high speed exit, software reset, power commands, ignored transfers and reference
  a_abort_pulse: assert property (@(posedge clk) disable iff (!nrst)
    clr_fall && busy_q |=> xfer_abort ##1 !xfer_abort)
    else $error("abort notice not a single pulse");
  a_abort_drop: assert property (@(posedge clk) disable iff (!nrst)
    clr_fall && busy_q && !xfer_start |=> xfer_ignore)
    else $error("aborted write not dropped");
  a_hs_pulse: assert property (@(posedge clk) disable iff (!nrst)
    hs_exit |=> !hs_exit)
    else $error("high speed exit held too long");
  a_swrst_zero: assert property (@(posedge clk) disable iff (!nrst)
    do_swrst |=> {dac_q[0], in_q[0], dac_q[1], in_q[1]} == '0)
    else $error("software reset did not zero codes");
  a_part_keep: assert property (@(posedge clk) disable iff (!nrst)
    do_swrst && !cmd.data[0] && !apb_wr |=> $stable(ref_on) && $stable(mask_q) && $stable(power_mode))
    else $error("partial reset touched setup");
  a_mode_keep: assert property (@(posedge clk) disable iff (!nrst)
    do_power && in_wr == '0 && !ls_fall |=> $stable(dac_q[0]) && $stable(dac_q[1]))
    else $error("power command changed a code");
  a_pwr_sel_b: assert property (@(posedge clk) disable iff (!nrst)
    do_power && cmd.data[1] |=> power_mode[3:2] == $past(cmd.data[5:4]))
    else $error("power mode B not taken");
  a_ignore_cmd: assert property (@(posedge clk) disable iff (!nrst)
    xfer_ignore && cmd_valid |=> $stable(power_mode) && $stable(ref_on))
    else $error("ignored transfer changed setup");
  a_ref_por: assert property (@(posedge clk) disable iff (!nrst)
    por_busy |-> !ref_on)
    else $error("reference on during power-up");
  a_ref_keep: assert property (@(posedge clk) disable iff (!nrst)
    !do_ref && !full_rst |=> $stable(ref_on))
    else $error("reference changed without command");

endmodule // dmc_ctrl

// >>> verif/dmc_host_model.sv
// host serial controller model: write frames of nine scl pulses
// assumes the block samples scl on clk; scl stands high between frames
`timescale 1ns/1ps
module dmc_host_model
  import dmc_pkg::*;
(
  // clock
  input  wire logic         clk,
  // engine side
  output logic              scl = 1'h1,
  output logic              xfer_start = 1'h0,
  output logic              last_ack = 1'h0,
  output logic              hs_mode = 1'h0,
  output logic              cmd_valid = 1'h0,
  output dmc_cmd_s          cmd = '0,
  output logic [NCH-1:0]    in_wr = '0,
  output logic [CODE_W-1:0] in_data = '0
);
  // one frame: start, nine pulses, word and input write on the ninth
  task automatic frame(input dmc_cmd_s c, input logic [NCH-1:0] w, input logic [CODE_W-1:0] d, input logic hs);
    @(posedge clk);
    xfer_start <= 1'h1;
    hs_mode    <= hs;
    scl        <= 1'h0;
    @(posedge clk);
    xfer_start <= 1'h0;
    for (int i = 0; i < 9; i++) begin
      // scl low four clocks, then high four: a 320 ns period
      repeat (4) @(posedge clk);
      scl       <= 1'h1;
      last_ack  <= (i == 8);
      cmd_valid <= (i == 8);
      in_wr     <= (i == 8) ? w : '0;
      cmd       <= c;
      in_data   <= d;
      @(posedge clk);
      cmd_valid <= 1'h0;
      in_wr     <= '0;
      // released word lines flip rather than hold
      cmd       <= ~c;
      in_data   <= ~d;
      repeat (3) @(posedge clk);
      scl       <= 1'h0;
    end
    repeat (5) @(posedge clk);
    last_ack <= 1'h0;
    scl      <= 1'h1;
    hs_mode  <= 1'h0;
  endtask
endmodule // dmc_host_model

// >>> verif/tb_top.sv
// bench for the converter mode, reset and clear control
// assumes the host model drives the engine side; clear line has a pull-up
`timescale 1ns/1ps
module tb_top
  import dmc_pkg::*;
();
  logic                  clk, nrst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]            paddr;
  logic [31:0]           pwdata, prdata, rd;
  logic                  scl, xfer_start, last_ack, hs_mode, cmd_valid, xfer_ignore, xfer_abort, hs_exit;
  logic                  load_strobe_n, clr_drv_n, zero_output_n_o, zero_output_n_oe, ref_on, abort_seen, hs_seen;
  dmc_cmd_s              cmd;
  logic [NCH-1:0]        in_wr;
  logic [CODE_W-1:0]     in_data;
  logic [NCH*CODE_W-1:0] out_code;
  logic [3:0]            power_mode, pm_exp;
  wire                   zero_output_n_i;
  int                    fails, checked, cycles, low_cnt;
  // open-drain clear line, pulled up
  assign zero_output_n_i = clr_drv_n & (zero_output_n_oe | zero_output_n_o);
  dmc_ctrl dut (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .scl,
    .xfer_start, .last_ack, .hs_mode, .cmd_valid, .cmd, .in_wr, .in_data, .xfer_ignore, .xfer_abort, .hs_exit,
    .load_strobe_n, .zero_output_n_i, .zero_output_n_o, .zero_output_n_oe, .out_code, .power_mode, .ref_on);
  dmc_host_model host (.clk, .scl, .xfer_start, .last_ack, .hs_mode, .cmd_valid, .cmd, .in_wr, .in_data);
  // 25 MHz clock
  always #20 clk = ~clk;
  // watchdog, pulse latches, clear-low count
  always @(posedge clk) begin
    cycles++;
    if (zero_output_n_i === 1'h0) low_cnt++;
    if (xfer_abort === 1'h1) abort_seen <= 1'h1;
    if (hs_exit === 1'h1) hs_seen <= 1'h1;
    if (cycles == 8000) begin
      fails++;
      stop_test();
    end
  end
  // compare one value and count it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // verdict and end of run
  task automatic stop_test();
    if (fails == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one apb transfer; read data and error into rd and err
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  function automatic dmc_cmd_s mk(input logic [2:0] op, input logic [15:0] d, input logic r = 1'h0);
    mk = '{r, 1'h1, op, 3'h5, d};
  endfunction
  // power command with don't-care bits set
  task automatic pw(input logic [1:0] m, input logic [1:0] s, input logic r = 1'h0);
    host.frame(mk(OP_POWER, {10'h3FF, m, 2'h3, s}, r), '0, '0, 1'h0);
  endtask
  // data frame writing input registers
  task automatic wr(input logic [1:0] w, input logic [15:0] d, input logic hs = 1'h0);
    host.frame(mk(3'h0, d), w, d, hs);
  endtask
  // load strobe pulse
  task automatic strobe();
    @(posedge clk);
    load_strobe_n <= 1'h0;
    repeat (4) @(posedge clk);
    load_strobe_n <= 1'h1;
    repeat (6) @(posedge clk);
  endtask
  // every mode per channel, other channel kept
  task automatic t_power();
    for (int i = 0; i < 8; i++) begin
      pw(2'(i), i < 4 ? 2'h1 : 2'h2);
      if (i < 4) pm_exp[1:0] = 2'(i);
      else pm_exp[3:2] = 2'(i);
      chk(power_mode, pm_exp);
    end
    pw(2'h1, 2'h3);
    chk(power_mode, 4'h5);
    pw(2'h2, 2'h0);
    chk(power_mode, 4'h5);
    pw(2'h2, 2'h3, 1'h1);
    chk(power_mode, 4'h5);
  endtask
  task automatic t_retain();
    wr(2'h1, 16'h1234);
    chk(out_code, 32'h1234);
    pw(2'h2, 2'h1);
    chk(out_code, 32'h1234);
    pw(2'h0, 2'h1);
    chk(out_code, 32'h1234);
  endtask
  // clear mid-write in high speed mode
  task automatic t_clear();
    apb(1'h1, OFF_STRB_MASK, 32'h0);
    wr(2'h2, 16'hABCD);
    abort_seen <= 1'h0;
    hs_seen    <= 1'h0;
    fork
      wr(2'h2, 16'h7777, 1'h1);
      begin
        repeat (30) @(posedge clk);
        clr_drv_n <= 1'h0;
      end
    join
    chk(out_code, 32'h0);
    chk({abort_seen, hs_seen}, 32'h3);
    apb(1'h0, OFF_STATUS, 32'h0);
    chk(rd, 32'h24);
    apb(1'h0, OFF_CODE_A, 32'h0);
    chk(rd, 32'h0);
    // a write while clear stays low ends the hold, but the strobe must not copy it
    wr(2'h1, 16'h2468);
    apb(1'h0, OFF_STATUS, 32'h0);
    chk(rd, 32'h4);
    strobe();
    chk(out_code, 32'h0);
    clr_drv_n <= 1'h1;
    repeat (4) @(posedge clk);
    wr(2'h1, 16'h5555);
    strobe();
    chk(out_code, 32'h5555);
  endtask
  task automatic t_swreset();
    host.frame(mk(OP_REFSET, 16'hFFFE), '0, '0, 1'h0);
    chk(ref_on, 32'h0);
    host.frame(mk(OP_REFSET, 16'h0001), '0, '0, 1'h0);
    chk(ref_on, 32'h1);
    apb(1'h1, OFF_STRB_MASK, 32'h2);
    pw(2'h1, 2'h3);
    host.frame(mk(OP_SWRESET, 16'hFFFE), '0, '0, 1'h0);
    chk({ref_on, power_mode, out_code[15:0]}, 32'h150000);
    apb(1'h0, OFF_STRB_MASK, 32'h0);
    chk(rd, 32'h2);
    low_cnt = 0;
    host.frame(mk(OP_SWRESET, 16'h0001), '0, '0, 1'h0);
    fork
      pw(2'h2, 2'h3);
      begin
        repeat (20) @(posedge clk);
        chk(xfer_ignore, 32'h1);
      end
    join
    wait (zero_output_n_oe === 1'h1);
    chk(low_cnt, SWRST_CYCLES);
    chk({ref_on, power_mode}, 32'h0);
    apb(1'h0, OFF_STRB_MASK, 32'h0);
    chk(rd, 32'h0);
    pw(2'h2, 2'h2);
    chk(power_mode, 4'h8);
  endtask
  // reset, power-up state, then each scenario
  initial begin
    clk = 1'h0;
    nrst = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = '0;
    pwdata = '0;
    load_strobe_n = 1'h1;
    clr_drv_n = 1'h1;
    pm_exp = '0;
    repeat (8) @(posedge clk);
    nrst <= 1'h1;
    repeat (20) @(posedge clk);
    chk({ref_on, power_mode, out_code}, 32'h0);
    apb(1'h0, OFF_STATUS, 32'h0);
    chk(rd, 32'h20);
    apb(1'h1, OFF_STRB_MASK, 32'h3);
    apb(1'h0, 8'h10, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    t_power();
    t_retain();
    t_clear();
    t_swreset();
    stop_test();
  end
endmodule // tb_top
